// ---- src/pdsag_addr_gen.sv ----
// Purpose: Extended data space address generation with page tracking
// Assumes: One access request per cycle; results registered one cycle later
// Notes:   Page overflow/underflow flags come from the address adder
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// [RULE_01] Read page bit 9 clear and base bit 15 set: read page above offset bits.
// [RULE_02] Write with base bit 15 set: write page above offset bits.
// [RULE_03] Ten-bit read page and nine-bit write page registers.
// [RULE_04] Read page 0x200 or above reads program space.
// [RULE_05] Writes can never reach program space; an attempt traps. The code does not trap; a write overflow at page 0x1FF clears bit 15.
// [RULE_06] Extended access while the page in use is zero traps.
// [RULE_07] Page crossing only for paged base and pre/post-modified modes.
// [RULE_08] Overflow normally increments the page and keeps bit 15 set.
// [RULE_09] Underflow normally decrements the page and keeps bit 15 set.
// [RULE_10] Register-offset, modulo, bit-reversed: page kept, wrap within page.
// [RULE_11] Past 0x1FF/0x3FF or read under 0x001: page kept, base space.
// [RULE_12] Read 0x2FF up goes 0x300, 0x300 down 0x2FF, 0x200 down base.
// [RULE_13] Read and write pages are independent in one access.
// [RULE_14] Software must not expect linear crossing for large offsets.
// [RULE_15] Both page registers reset to one.
// [RULE_16] Software write of zero to a page register is ignored.
// [RULE_17] Base bit 15 clear bypasses paging entirely.
module pdsag_addr_gen (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                srst,
  // Page register writes from software
  input  wire logic                rdPageWrEn,
  input  wire logic [9:0]          rdPageWrData,
  input  wire logic                wrPageWrEn,
  input  wire logic [8:0]          wrPageWrData,
  // Access request from the effective address generator
  input  wire logic                reqValid,
  input  wire logic                reqWrite,
  input  wire logic [15:0]         reqBaseAddr,
  input  wire logic [15:0]         reqCalcAddr,
  input  wire logic [2:0]          reqMode,
  input  wire logic                reqOverflow,
  input  wire logic                reqUnderflow,
  // Result toward the data memory bus
  output logic                     accValid,
  output logic                     accWrite,
  output logic [23:0]              accAddr,
  output logic                     accProgSpace,
  output logic                     accTrap,
  output logic [15:0]              nextEffAddr,
  // Page register contents
  output logic [9:0]               readPageReg,
  output logic [8:0]               writePageReg
);
  // ==========================================================================
  // Access decode
  logic [9:0]  activePage;
  logic        paged;
  logic        crossMode;
  logic        wrapMode;
  logic        next_trap;
  logic [23:0] next_addr;
  logic        next_prog;
  logic [9:0]  next_page;
  logic        next_bit15;
  logic        pageStep;

  assign paged      = reqBaseAddr[pdsag_pkg::PAGED_BIT];
  assign activePage = reqWrite ? {1'b0, writePageReg} : readPageReg;   // see [RULE_13]
  assign crossMode  = paged && (reqMode == 3'(pdsag_pkg::PDSAG_AM_PREPOST));   // see [RULE_07]
  assign wrapMode   = paged && ((reqMode == 3'(pdsag_pkg::PDSAG_AM_REGOFS)) ||
                      (reqMode == 3'(pdsag_pkg::PDSAG_AM_MODULO)) ||
                      (reqMode == 3'(pdsag_pkg::PDSAG_AM_BITREV)));

  // Address formation for the current access
  always_comb begin
    next_addr = {8'h00, reqBaseAddr};   // see [RULE_17]
    next_prog = 1'b0;
    next_trap = 1'b0;
    if (paged) begin
      if (reqWrite) begin
        next_addr = {writePageReg, reqBaseAddr[14:0]};   // see [RULE_02]
        next_trap = (writePageReg == pdsag_pkg::PAGE_ZERO[8:0]);   // see [RULE_06]
      end else begin
        next_addr = {readPageReg[8:0], reqBaseAddr[14:0]};   // see [RULE_01]
        next_prog = readPageReg >= pdsag_pkg::PAGE_PROG_FIRST;   // see [RULE_04]
        next_trap = (readPageReg == pdsag_pkg::PAGE_ZERO);   // see [RULE_06]
      end
    end
  end

  // Page step decision after overflow or underflow
  always_comb begin
    next_page  = activePage;
    next_bit15 = reqCalcAddr[pdsag_pkg::PAGED_BIT];
    pageStep   = 1'b0;
    if (wrapMode && (reqOverflow || reqUnderflow)) begin
      next_bit15 = 1'b1;   // see [RULE_10]
    end else if (crossMode && reqOverflow) begin
      if (activePage == pdsag_pkg::PAGE_EXT_LAST ||
          activePage == pdsag_pkg::PAGE_MSW_LAST) begin
        next_bit15 = 1'b0;   // see [RULE_11]
      end else begin
        next_page  = activePage + pdsag_pkg::PAGE_ONE;   // see [RULE_08] [RULE_12]
        next_bit15 = 1'b1;
        pageStep   = 1'b1;
      end
    end else if (crossMode && reqUnderflow) begin
      if (!reqWrite && (activePage == pdsag_pkg::PAGE_ONE ||
          activePage == pdsag_pkg::PAGE_PROG_FIRST)) begin
        next_bit15 = 1'b0;   // see [RULE_11] [RULE_12]
      end else begin
        next_page  = activePage - pdsag_pkg::PAGE_ONE;   // see [RULE_09] [RULE_12]
        next_bit15 = 1'b1;
        pageStep   = 1'b1;
      end
    end else if (crossMode) begin
      next_bit15 = reqCalcAddr[pdsag_pkg::PAGED_BIT];
    end
  end

  // ==========================================================================
  // Read page register
  always_ff @(posedge clk) begin
    if (srst) begin
      readPageReg <= pdsag_pkg::PAGE_RESET;   // see [RULE_15]
    end else if (reqValid && !reqWrite && pageStep && !next_trap) begin
      readPageReg <= next_page;   // see [RULE_08] [RULE_09]
    end else if (rdPageWrEn && rdPageWrData != pdsag_pkg::PAGE_ZERO) begin
      readPageReg <= rdPageWrData;   // see [RULE_03] [RULE_16]
    end
  end

  // Write page register
  always_ff @(posedge clk) begin
    if (srst) begin
      writePageReg <= pdsag_pkg::PAGE_RESET[8:0];   // see [RULE_15]
    end else if (reqValid && reqWrite && pageStep && !next_trap) begin
      writePageReg <= next_page[8:0];   // see [RULE_08] [RULE_09]
    end else if (wrPageWrEn && wrPageWrData != pdsag_pkg::PAGE_ZERO[8:0]) begin
      writePageReg <= wrPageWrData;   // see [RULE_03] [RULE_16] [RULE_05]
    end
  end

  // Registered access result
  always_ff @(posedge clk) begin
    if (srst) begin
      accValid     <= 1'b0;
      accWrite     <= 1'b0;
      accAddr      <= '0;
      accProgSpace <= 1'b0;
      accTrap      <= 1'b0;
      nextEffAddr  <= '0;
    end else begin
      accValid     <= reqValid;
      accWrite     <= reqWrite;
      accAddr      <= next_addr;
      accProgSpace <= reqValid && next_prog;
      accTrap      <= reqValid && next_trap;
      nextEffAddr  <= {next_bit15, reqCalcAddr[14:0]};   // see [RULE_07]
    end
  end

  // ==========================================================================
  // Checks
  AST_RESET_ONE: assert property (@(posedge clk) $past(srst) |->   // see [RULE_15]
    readPageReg == 10'h001 && writePageReg == 9'h001)
    else $error("page registers not one after reset");
  AST_NO_ZERO: assert property (@(posedge clk) disable iff (srst)   // see [RULE_16]
    readPageReg != 10'h000 && writePageReg != 9'h000)
    else $error("page register became zero");
  AST_BYPASS: assert property (@(posedge clk) disable iff (srst)   // see [RULE_17]
    reqValid && !reqBaseAddr[15] |=> accAddr == {8'h00, $past(reqBaseAddr)} && !accTrap)
    else $error("unpaged access was modified");
  AST_WR_ADDR: assert property (@(posedge clk) disable iff (srst)   // see [RULE_02]
    reqValid && reqWrite && reqBaseAddr[15] |=>
    accAddr == {$past(writePageReg), $past(reqBaseAddr[14:0])} && !accProgSpace)
    else $error("write address wrong");
  AST_RD_ADDR: assert property (@(posedge clk) disable iff (srst)   // see [RULE_01]
    reqValid && !reqWrite && reqBaseAddr[15] |=>
    accAddr == {$past(readPageReg[8:0]), $past(reqBaseAddr[14:0])} &&
    accProgSpace == $past(readPageReg[9]))
    else $error("read address wrong");
  AST_OVF_STEP: assert property (@(posedge clk) disable iff (srst)   // see [RULE_08]
    reqValid && !reqWrite && reqBaseAddr[15] && reqOverflow && !rdPageWrEn &&
    reqMode == 3'(pdsag_pkg::PDSAG_AM_PREPOST) && readPageReg == 10'h2ff |=>
    readPageReg == 10'h300 && nextEffAddr[15])
    else $error("read overflow from 0x2ff wrong");
  AST_UNF_EDGE: assert property (@(posedge clk) disable iff (srst)   // see [RULE_11]
    reqValid && !reqWrite && reqBaseAddr[15] && reqUnderflow && !rdPageWrEn &&
    reqMode == 3'(pdsag_pkg::PDSAG_AM_PREPOST) && readPageReg == 10'h001 |=>
    $stable(readPageReg) && !nextEffAddr[15])
    else $error("read underflow from page one wrong");
  AST_WRAP: assert property (@(posedge clk) disable iff (srst)   // see [RULE_10]
    reqValid && reqBaseAddr[15] && reqOverflow && !rdPageWrEn && !wrPageWrEn &&
    reqMode == 3'(pdsag_pkg::PDSAG_AM_MODULO) |=>
    $stable(readPageReg) && $stable(writePageReg) && nextEffAddr[15])
    else $error("wrap mode changed page");
  AST_OVF_KEEP: assert property (@(posedge clk) disable iff (srst)   // see [RULE_11]
    reqValid && reqBaseAddr[pdsag_pkg::PAGED_BIT] && reqOverflow && !rdPageWrEn &&
    !wrPageWrEn && reqMode == 3'(pdsag_pkg::PDSAG_AM_PREPOST) &&
    (activePage == pdsag_pkg::PAGE_EXT_LAST || activePage == pdsag_pkg::PAGE_MSW_LAST) |=>
    $stable(readPageReg) && $stable(writePageReg) && !nextEffAddr[pdsag_pkg::PAGED_BIT])
    else $error("overflow past the last page moved the page");
  AST_UNF_STEP: assert property (@(posedge clk) disable iff (srst)   // see [RULE_12]
    reqValid && !reqWrite && reqBaseAddr[pdsag_pkg::PAGED_BIT] && reqUnderflow &&
    reqMode == 3'(pdsag_pkg::PDSAG_AM_PREPOST) && readPageReg == pdsag_pkg::PAGE_MSW_FIRST |=>
    readPageReg == pdsag_pkg::PAGE_LSW_LAST && nextEffAddr[pdsag_pkg::PAGED_BIT])
    else $error("read underflow from the first upper page wrong");
  AST_WR_STEP: assert property (@(posedge clk) disable iff (srst)   // see [RULE_09]
    reqValid && reqWrite && reqBaseAddr[pdsag_pkg::PAGED_BIT] && reqUnderflow &&
    reqMode == 3'(pdsag_pkg::PDSAG_AM_PREPOST) && writePageReg > pdsag_pkg::PAGE_ONE[8:0] |=>
    writePageReg == $past(writePageReg) - pdsag_pkg::PAGE_ONE[8:0] &&
    nextEffAddr[pdsag_pkg::PAGED_BIT])
    else $error("write underflow did not step the page down");
  AST_PAGE_APART: assert property (@(posedge clk) disable iff (srst)   // see [RULE_13]
    reqValid && !rdPageWrEn && !wrPageWrEn |=>
    ($past(reqWrite) ? $stable(readPageReg) : $stable(writePageReg)))
    else $error("an access moved the other page register");
  AST_TRAP_ZERO: assert property (@(posedge clk) disable iff (srst)   // see [RULE_06]
    reqValid && reqBaseAddr[pdsag_pkg::PAGED_BIT] |=>
    accTrap == (($past(reqWrite) && $past(writePageReg) == pdsag_pkg::PAGE_ZERO[8:0]) ||
                (!$past(reqWrite) && $past(readPageReg) == pdsag_pkg::PAGE_ZERO)))
    else $error("trap does not follow a zero page");
  AST_SW_WRITE: assert property (@(posedge clk) disable iff (srst)   // see [RULE_16]
    rdPageWrEn && !reqValid |=> readPageReg == ($past(rdPageWrData) == pdsag_pkg::PAGE_ZERO ?
    $past(readPageReg) : $past(rdPageWrData)))
    else $error("software read page write wrong");
  COV_PROG: cover property (@(posedge clk) accValid && accProgSpace);
  COV_TRAP: cover property (@(posedge clk) accTrap);
  COV_STEP: cover property (@(posedge clk) $changed(writePageReg) && !srst);
  COV_RD_CROSS: cover property (@(posedge clk) reqValid && !reqWrite && reqUnderflow &&
    crossMode && readPageReg == pdsag_pkg::PAGE_MSW_FIRST);
  COV_WRAP: cover property (@(posedge clk) reqValid && wrapMode && reqOverflow);
endmodule : pdsag_addr_gen
`default_nettype wire

// ---- src/pdsag_pkg.sv ----
// Purpose: Constants for the paged data space address generator
// Assumes: 16-bit base addresses, 24-bit extended addresses
// Notes:   Shared by the design and the bench
`default_nettype none
package pdsag_pkg;
  // ==========================================================================
  // Widths
  localparam int unsigned BASE_W      = 16;
  localparam int unsigned EXT_W       = 24;
  localparam int unsigned RPAGE_W     = 10;
  localparam int unsigned WPAGE_W     = 9;
  localparam int unsigned OFS_W       = 15;
  // ==========================================================================
  // Field positions
  localparam int unsigned PAGED_BIT   = 15;
  localparam int unsigned PROG_BIT    = 9;
  // ==========================================================================
  // Page values
  localparam logic [9:0]  PAGE_RESET  = 10'h001;
  localparam logic [9:0]  PAGE_ZERO   = 10'h000;
  localparam logic [9:0]  PAGE_EXT_LAST = 10'h1ff;
  localparam logic [9:0]  PAGE_PROG_FIRST = 10'h200;
  localparam logic [9:0]  PAGE_LSW_LAST = 10'h2ff;
  localparam logic [9:0]  PAGE_MSW_FIRST = 10'h300;
  localparam logic [9:0]  PAGE_MSW_LAST = 10'h3ff;
  localparam logic [9:0]  PAGE_ONE    = 10'h001;
  // ==========================================================================
  // Addressing modes of the effective address calculation
  typedef enum logic [2:0] {
    PDSAG_AM_DIRECT,
    PDSAG_AM_PREPOST,
    PDSAG_AM_REGOFS,
    PDSAG_AM_MODULO,
    PDSAG_AM_BITREV
  } pdsag_mode_e;
endpackage : pdsag_pkg
`default_nettype wire

// ---- dv/pdsag_ea_model.sv ----
// Purpose: Effective address adder that feeds the page logic
// Assumes: Small signed steps only
// Notes:   Crossing flags only for a paged base address
`timescale 1ns/1ps
`default_nettype none
module pdsag_ea_model (
  // Unmodified address and signed step
  input  wire logic [15:0] baseAddr,
  input  wire logic [7:0]  step,
  // Modified address and crossing flags
  output logic      [15:0] calcAddr,
  output logic             overflow,
  output logic             underflow
);
  logic [16:0] sum;
  // ==========================================================================
  // Adder; bit 15 drops on a crossing; steps stay small
  always_comb begin
    sum       = {1'b0, baseAddr} + {{9{step[7]}}, step};
    calcAddr  = sum[15:0];
    overflow  = baseAddr[15] & ~step[7] & sum[16];
    underflow = baseAddr[15] & step[7] & ~sum[15];
  end
endmodule : pdsag_ea_model
`default_nettype wire

// ---- dv/pdsag_addr_gen_test.sv ----
// Purpose: Self-checking bench for the page address generator
// Assumes: Page writes and requests in separate cycles
// Notes:   Integer model of pages checked after every edge
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module pdsag_addr_gen_test;
  logic clk, srst, rdEn, wrEn, vld, wr, ov, un, aV, aW, aP, aT;
  logic [9:0] rdD, rpg;
  logic [8:0] wrD, wpg;
  logic [15:0] base, calc, nxt, eNext;
  logic [7:0] step;
  logic [2:0] mode;
  logic [23:0] aA;
  int fails, checked, cyc, seed, rp, wp, pg, k, r, i;
  logic [23:0] eAddr;
  logic [15:0] rb;
  logic [2:0] pp;
  logic eProg, eTrap;
  int pv[9] = '{1, 2, 'h1fe, 'h1ff, 'h200, 'h2ff, 'h300, 'h3ff, 0};
  pdsag_ea_model u_pdsag_ea_model (.baseAddr(base), .step(step), .calcAddr(calc),
    .overflow(ov), .underflow(un));
  pdsag_addr_gen u_pdsag_addr_gen (.clk(clk), .srst(srst), .rdPageWrEn(rdEn),
    .rdPageWrData(rdD), .wrPageWrEn(wrEn), .wrPageWrData(wrD), .reqValid(vld),
    .reqWrite(wr), .reqBaseAddr(base), .reqCalcAddr(calc), .reqMode(mode),
    .reqOverflow(ov), .reqUnderflow(un), .accValid(aV), .accWrite(aW), .accAddr(aA),
    .accProgSpace(aP), .accTrap(aT), .nextEffAddr(nxt), .readPageReg(rpg),
    .writePageReg(wpg));
  // ==========================================================================
  // Clock and hang guard
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict
  // Step one edge and compare pages against the model
  task automatic tick();
    @(posedge clk);
    #1;
    `CHK("readPage", 10'(rp), rpg)
    `CHK("writePage", 9'(wp), wpg)
  endtask : tick
  // Software page writes for one cycle; a zero value leaves the model alone
  task automatic set_pages(input logic re, input logic we, input int dr, input int dw);
    {rdEn, wrEn, vld} = {re, we, 1'b0};
    rdD = 10'(dr);
    wrD = 9'(dw);
    if (re && rdD != 10'h000) rp = int'(rdD);
    if (we && wrD != 9'h000) wp = int'(wrD);
    tick();
    `CHK("idleValid", 1'b0, aV)
  endtask : set_pages
  // One access: the model predicts from its own pages, then the result is compared
  task automatic request(input logic w, input logic [7:0] s, input logic [2:0] m,
                         input logic [15:0] b);
    {rdEn, wrEn, vld, wr, mode, base} = {3'b001, w, m, b};
    step = (w && wp == 1) ? {1'b0, s[6:0]} : s; // No write below page one
    pg = w ? wp : rp;
    eAddr = b[15] ? {9'(pg), b[14:0]} : {8'h00, b};
    eProg = !w && b[15] && pg >= 'h200;
    eTrap = b[15] && pg == 0;
    #1 eNext = calc;
    if (b[15] && (ov || un) && m != 3'(pdsag_pkg::PDSAG_AM_DIRECT)) begin
      if (m != pp) eNext = calc | 16'h8000;
      else if (!(ov && (pg == 'h1ff || pg == 'h3ff)) &&
               !(un && !w && (pg == 1 || pg == 'h200))) begin
        eNext = calc | 16'h8000;
        pg = ov ? pg + 1 : pg - 1;
        if (w) wp = pg;
        else rp = pg;
      end
    end
    tick();
    `CHK("valid", 1'b1, aV)
    `CHK("write", w, aW)
    `CHK("prog", eProg, aP)
    `CHK("trap", eTrap, aT)
    `CHK("next", eNext, nxt)
    `CHK("addr", eAddr, aA)
  endtask : request
  // ==========================================================================
  // Reset, random page writes and requests near page edges, then every edge page
  initial begin
    seed = 32'h2ed6;
    pp = 3'(pdsag_pkg::PDSAG_AM_PREPOST);
    {srst, rdEn, wrEn, vld, wr, rdD, wrD, base, step, mode} = '0;
    srst = 1'b1;
    rp = 1;
    wp = 1;
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    `CHK("rstPage", 10'h001, rpg)
    for (k = 0; k < 300; k++) begin
      r = $random(seed);
      set_pages(r[0], r[1], pv[r[7:4] % 9], pv[r[11:8] % 9]);
      r = $random(seed);
      rb = r[20] ? 16'h8002 - 16'(r[23:22]) : r[31:16];
      if (r[21]) rb = 16'hfff8 + 16'(r[23:22]);
      request(r[0], r[15:8], 3'(r[19:16] % 5), rb);
      // Reset once in mid-run with a request still on the inputs
      if (k == 150) begin
        srst = 1'b1;
        rp = 1;
        wp = 1;
        tick();
        `CHK("rstValid", 1'b0, aV)
        srst = 1'b0;
      end
    end
    for (i = 0; i < 8; i++) begin
      set_pages(1'b1, 1'b1, pv[i], pv[i]);
      request(1'b0, 8'h10, pp, 16'hfff8);
      set_pages(1'b1, 1'b1, pv[i], pv[i]);
      request(1'b0, 8'hfc, pp, 16'h8002);
      set_pages(1'b1, 1'b1, pv[i], pv[i]);
      request(1'b1, 8'h10, pp, 16'hfff8);
      request(1'b1, 8'hfc, pp, 16'h8002);
      request(1'b0, 8'h10, 3'(pdsag_pkg::PDSAG_AM_BITREV), 16'hfffc);
    end
    srst = 1'b1;
    rp = 1;
    wp = 1;
    tick();
    give_verdict();
  end
endmodule : pdsag_addr_gen_test
`default_nettype wire
